// ==== core/ecs_engine.sv ====
// ecc unit status, ecc clear and crc-32c checksum engine behind a serial link
`timescale 1ns/1ps

// ------------------------------------------------------------
// link output drive, cleared whenever chip select is high
// ------------------------------------------------------------
module ecs_link_drive (
    input  wire logic             sck,
    input  wire logic             linkRst,
    input  wire logic             drive,
    input  wire logic [3:0]       outBits,
    input  wire logic [3:0]       oeMaskN,
    output ecs_pkg::ecs_drv_t     q
);
    import ecs_pkg::*;

    ecs_drv_t d_ff;
    ecs_drv_t nxt_d;

    always_comb begin
        nxt_d        = d_ff;
        nxt_d.active = 1'b1;
        nxt_d.ioOut  = drive ? outBits : 4'h0;
        nxt_d.ioOeN  = drive ? oeMaskN : 4'hf;
    end

    always_ff @(posedge sck or posedge linkRst) begin
        if (linkRst) begin
            d_ff <= '0;
            d_ff.ioOeN <= 4'hf;
        end else begin
            d_ff <= nxt_d;
        end
    end

    assign q = d_ff;
endmodule : ecs_link_drive

module ecs_engine #(
    parameter int CALC_CYC = ecs_pkg::CALC_CYC_DEF,
    parameter int SUSP_CYC = ecs_pkg::SUSP_CYC_DEF,
    parameter int RES_CYC  = ecs_pkg::RES_CYC_DEF
) (
    input  wire logic                clk,
    input  wire logic                sys_rst,
    input  wire logic                sck,
    input  wire logic                csN,
    input  wire logic [3:0]          ioIn,
    output      logic [3:0]          ioOut,
    output      logic [3:0]          ioOeN,
    input  wire logic [1:0]          laneMode,
    input  wire logic [3:0]          memoryLatencyCode,
    input  wire logic                writeEnableLatch,
    output      logic                writeEnableLatchClr,
    output ecs_pkg::ecs_memreq_t     memReq,
    input  wire logic                memValid,
    input  wire logic [7:0]          memData,
    input  ecs_pkg::ecs_eccev_t      eccEvent,
    output ecs_pkg::ecs_status_t     status,
    output      logic [31:0]         checksumResultReg,
    output      logic [31:0]         firstErrorAddressTrap,
    output      logic [15:0]         doubleErrorCounter
);
    import ecs_pkg::*;

    // ------------------------------------------------------------
    // state types
    // ------------------------------------------------------------
    typedef struct packed {
        ecs_state_t        state;
        logic [ADDR_W-1:0] ptr;
        logic [ADDR_W-1:0] endA;
        logic [31:0]       word;
        logic [1:0]        bcnt;
        logic [31:0]       crc;
        logic [15:0]       tmr;
        logic              suspReq;
        logic              welPend;
        ecs_status_t       stat;
        logic              welClr;
        ecs_memreq_t       mem;
        logic [2:0]        csSync;
        logic [2:0]        reqSync;
        logic              ansBit;
        logic [31:0]       trap;
        logic              trapVal;
        logic [15:0]       dcnt;
    } ecs_core_t;

    typedef struct packed {
        logic [55:0] sh;
        logic [6:0]  nbits;
        logic        ecc_unit_status_cmd;
        logic        reqTgl;
        logic [23:0] uAddr;
        logic [1:0]  laneS1;
        logic [1:0]  laneS2;
        logic [3:0]  latS1;
        logic [3:0]  latS2;
        logic        ansS1;
        logic        ansS2;
    } ecs_frame_t;

    ecs_core_t  c_ff;
    ecs_core_t  nxt_c;
    ecs_frame_t f_ff;
    ecs_frame_t nxt_f;
    ecs_drv_t   drvQ;
    logic       errMap [UNITS];
    logic       linkRst;
    logic       csRise;
    logic       reqEdge;
    logic       isClr;
    logic       isSus;
    logic       isRes;
    logic       isStart;
    logic [23:0] begA;
    logic [23:0] endA;
    logic       drive;
    logic [3:0] outBits;
    logic [3:0] oeMaskN;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] crcWord(input logic [31:0] cv,
                                            input logic [31:0] dv);
        logic [31:0] r;
        logic        fb;
        r  = cv;
        fb = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            fb = r[31] ^ dv[i];
            r  = {r[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h00000000);
        end
        return r;
    endfunction : crcWord

    function automatic logic [6:0] laneWidth(input logic [1:0] m);
        logic [6:0] w;
        unique case (m)
            LANE_DUAL: w = 7'h02;
            LANE_QUAD: w = 7'h04;
            default:   w = 7'h01;
        endcase
        return w;
    endfunction : laneWidth

    // ------------------------------------------------------------
    // command decode at chip select release
    // ------------------------------------------------------------
    assign csRise  = c_ff.csSync[1] & ~c_ff.csSync[2];
    assign reqEdge = c_ff.reqSync[1] ^ c_ff.reqSync[2];
    assign begA    = f_ff.sh[47:24];
    assign endA    = f_ff.sh[23:0];
    assign isClr   = csRise && f_ff.nbits == OPC_BITS
                     && f_ff.sh[7:0] == OPC_ECC_CLEAR;
    assign isSus   = csRise && f_ff.nbits == OPC_BITS
                     && f_ff.sh[7:0] == OPC_CK_SUSPEND;
    assign isRes   = csRise && f_ff.nbits == OPC_BITS
                     && f_ff.sh[7:0] == OPC_CK_RESUME;
    assign isStart = csRise && f_ff.nbits == RANGE_BITS
                     && f_ff.sh[55:48] == OPC_CK_START;

    // ------------------------------------------------------------
    // core state on the system clock
    // ------------------------------------------------------------
    always_comb begin
        nxt_c         = c_ff;
        nxt_c.csSync  = {c_ff.csSync[1:0], csN};
        nxt_c.reqSync = {c_ff.reqSync[1:0], f_ff.reqTgl};
        nxt_c.welClr  = 1'b0;
        nxt_c.mem.req = 1'b0;

        if (reqEdge) begin
            nxt_c.ansBit = errMap[f_ff.uAddr[ADDR_W-1:UNIT_LSB]];
        end

        // clear first so that a same-cycle detection survives
        if (isClr) begin
            nxt_c.trap    = TRAP_RST;
            nxt_c.trapVal = 1'b0;
            nxt_c.dcnt    = CNT_RST;
        end
        if (eccEvent.detect) begin
            if (!nxt_c.trapVal) begin
                nxt_c.trap    = {8'h00, eccEvent.addr[23:UNIT_LSB], 3'b000};
                nxt_c.trapVal = 1'b1;
            end
            if (nxt_c.dcnt != CNT_MAX) begin
                nxt_c.dcnt = nxt_c.dcnt + 16'h0001;
            end
        end

        if (isSus && (c_ff.state == ST_READ || c_ff.state == ST_WAIT)) begin
            nxt_c.suspReq = 1'b1;
        end

        unique case (c_ff.state)
            ST_IDLE: begin
                if (isStart) begin
                    nxt_c.crc = RESULT_RST;
                    nxt_c.stat.checksumAbortFlag = 1'b0;
                    if ({1'b0, endA} < {1'b0, begA} + MIN_SPAN) begin
                        nxt_c.stat.checksumAbortFlag = 1'b1;
                    end else begin
                        nxt_c.ptr     = begA[ADDR_W-1:0];
                        nxt_c.endA    = endA[ADDR_W-1:0];
                        nxt_c.bcnt    = 2'b00;
                        nxt_c.welPend = writeEnableLatch;
                        nxt_c.suspReq = 1'b0;
                        nxt_c.stat.opInProgress = 1'b1;
                        nxt_c.state   = ST_READ;
                    end
                end
            end
            ST_READ: begin
                if (c_ff.suspReq) begin
                    nxt_c.tmr   = 16'(SUSP_CYC);
                    nxt_c.state = ST_SUSPENDING;
                end else begin
                    nxt_c.mem.req  = 1'b1;
                    nxt_c.mem.addr = c_ff.ptr;
                    nxt_c.state    = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (memValid) begin
                    nxt_c.word = {c_ff.word[23:0], memData};
                    nxt_c.bcnt = c_ff.bcnt + 2'b01;
                    if (c_ff.bcnt == 2'b11) begin
                        nxt_c.crc = crcWord(c_ff.crc, nxt_c.word);
                    end
                    if (c_ff.ptr == c_ff.endA) begin
                        if (c_ff.bcnt != 2'b11) begin
                            nxt_c.crc = crcWord(c_ff.crc,
                                nxt_c.word << {2'b11 - c_ff.bcnt, 3'b000});
                        end
                        nxt_c.suspReq = 1'b0;
                        nxt_c.tmr     = 16'(CALC_CYC);
                        nxt_c.state   = ST_TAIL;
                    end else begin
                        nxt_c.ptr   = c_ff.ptr + 1'b1;
                        nxt_c.state = ST_READ;
                    end
                end
            end
            ST_TAIL: begin
                if (c_ff.tmr == 16'h0000) begin
                    nxt_c.stat.opInProgress = 1'b0;
                    nxt_c.welClr  = c_ff.welPend;
                    nxt_c.welPend = 1'b0;
                    nxt_c.state   = ST_IDLE;
                end else begin
                    nxt_c.tmr = c_ff.tmr - 16'h0001;
                end
            end
            ST_SUSPENDING: begin
                if (c_ff.tmr == 16'h0000) begin
                    nxt_c.stat.checksumSuspendedFlag = 1'b1;
                    nxt_c.stat.opInProgress = 1'b0;
                    nxt_c.suspReq = 1'b0;
                    nxt_c.state   = ST_SUSP;
                end else begin
                    nxt_c.tmr = c_ff.tmr - 16'h0001;
                end
            end
            ST_SUSP: begin
                // a new start is refused while suspended
                if (isRes && c_ff.stat.checksumSuspendedFlag) begin
                    nxt_c.stat.checksumSuspendedFlag = 1'b0;
                    nxt_c.stat.opInProgress = 1'b1;
                    nxt_c.tmr   = 16'(RES_CYC);
                    nxt_c.state = ST_RESUMING;
                end
            end
            ST_RESUMING: begin
                if (c_ff.tmr == 16'h0000) begin
                    nxt_c.state = ST_READ;
                end else begin
                    nxt_c.tmr = c_ff.tmr - 16'h0001;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            c_ff <= '0;
        end else begin
            c_ff <= nxt_c;
        end
    end

    // ------------------------------------------------------------
    // per-unit double error map
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < UNITS; i++) begin
                errMap[i] <= 1'b0;
            end
        end else begin
            if (isClr) begin
                for (int i = 0; i < UNITS; i++) begin
                    errMap[i] <= 1'b0;
                end
            end
            if (eccEvent.detect) begin
                errMap[eccEvent.addr[ADDR_W-1:UNIT_LSB]] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // frame capture on the link clock
    // ------------------------------------------------------------
    always_comb begin
        logic [55:0] bSh;
        logic [6:0]  bN;
        logic [6:0]  w;
        logic [6:0]  start;
        logic [6:0]  off;
        logic [7:0]  sb;
        logic [7:0]  sh8;
        bSh          = 56'h0;
        bN           = 7'h00;
        w            = 7'h01;
        start        = 7'h00;
        off          = 7'h00;
        sb           = 8'h00;
        sh8          = 8'h00;
        nxt_f        = f_ff;
        nxt_f.laneS1 = laneMode;
        nxt_f.laneS2 = f_ff.laneS1;
        nxt_f.latS1  = memoryLatencyCode;
        nxt_f.latS2  = f_ff.latS1;
        nxt_f.ansS1  = c_ff.ansBit;
        nxt_f.ansS2  = f_ff.ansS1;
        bSh = drvQ.active ? f_ff.sh : 56'h0;
        bN  = drvQ.active ? f_ff.nbits : 7'h00;
        if (!drvQ.active) begin
            nxt_f.ecc_unit_status_cmd = 1'b0;
        end
        w = laneWidth(f_ff.laneS2);
        unique case (f_ff.laneS2)
            LANE_DUAL: nxt_f.sh = {bSh[53:0], ioIn[1:0]};
            LANE_QUAD: nxt_f.sh = {bSh[51:0], ioIn};
            default:   nxt_f.sh = {bSh[54:0], ioIn[0]};
        endcase
        nxt_f.nbits = (bN > NBITS_SAT) ? bN : bN + w;
        if (nxt_f.nbits == ADR_BITS && nxt_f.sh[31:24] == OPC_ECC_STATUS) begin
            nxt_f.ecc_unit_status_cmd  = 1'b1;
            nxt_f.uAddr  = nxt_f.sh[23:0];
            nxt_f.reqTgl = ~f_ff.reqTgl;
        end
        start = ADR_BITS + ({3'b000, f_ff.latS2} * w);
        off   = nxt_f.nbits - start;
        drive = nxt_f.ecc_unit_status_cmd && nxt_f.nbits >= start
                && nxt_f.nbits < start + STAT_BITS;
        sb = 8'h00;
        sb[DBL_ERR_BIT] = f_ff.ansS2;
        sh8 = sb << off[2:0];
        unique case (f_ff.laneS2)
            LANE_DUAL: begin
                outBits = {2'b00, sh8[7:6]};
                oeMaskN = 4'hc;
            end
            LANE_QUAD: begin
                outBits = sh8[7:4];
                oeMaskN = 4'h0;
            end
            default: begin
                outBits = {2'b00, sh8[7], 1'b0};
                oeMaskN = 4'hd;
            end
        endcase
    end

    always_ff @(posedge sck or posedge sys_rst) begin
        if (sys_rst) begin
            f_ff <= '0;
        end else begin
            f_ff <= nxt_f;
        end
    end

    assign linkRst = sys_rst | csN;

    ecs_link_drive u_drive (
        .sck     (sck),
        .linkRst (linkRst),
        .drive   (drive),
        .outBits (outBits),
        .oeMaskN (oeMaskN),
        .q       (drvQ)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign ioOut                 = drvQ.ioOut;
    assign ioOeN                 = drvQ.ioOeN;
    assign writeEnableLatchClr   = c_ff.welClr;
    assign memReq                = c_ff.mem;
    assign status                = c_ff.stat;
    assign checksumResultReg     = c_ff.crc;
    assign firstErrorAddressTrap = c_ff.trap;
    assign doubleErrorCounter    = c_ff.dcnt;
endmodule : ecs_engine

// ==== core/ecs_pkg.sv ====
// constants and types of the ecc status and checksum engine
package ecs_pkg;
    localparam logic [7:0]  OPC_ECC_STATUS = 8'h19;
    localparam logic [7:0]  OPC_ECC_CLEAR  = 8'h1b;
    localparam logic [7:0]  OPC_CK_START   = 8'h5b;
    localparam logic [7:0]  OPC_CK_SUSPEND = 8'h75;
    localparam logic [7:0]  OPC_CK_RESUME  = 8'h7a;
    localparam logic [31:0] CRC_POLY       = 32'h1edc6f41;
    localparam logic [31:0] RESULT_RST     = 32'h00000000;
    localparam logic [31:0] TRAP_RST       = 32'h00000000;
    localparam logic [15:0] CNT_RST        = 16'h0000;
    localparam logic [15:0] CNT_MAX        = 16'hffff;
    localparam int          ADDR_W         = 18;
    localparam int          UNIT_LSB       = 3;
    localparam int          UNITS          = 32768;
    localparam int          DBL_ERR_BIT    = 3;
    localparam logic [6:0]  OPC_BITS       = 7'h08;
    localparam logic [6:0]  ADR_BITS       = 7'h20;
    localparam logic [6:0]  RANGE_BITS     = 7'h38;
    localparam logic [6:0]  STAT_BITS      = 7'h08;
    localparam logic [6:0]  NBITS_SAT      = 7'h78;
    localparam logic [24:0] MIN_SPAN       = 25'h0000003;
    localparam int          CALC_CYC_DEF   = 4;
    localparam int          SUSP_CYC_DEF   = 8;
    localparam int          RES_CYC_DEF    = 8;

    typedef enum logic [1:0] {
        LANE_SINGLE,
        LANE_DUAL,
        LANE_QUAD
    } ecs_lane_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_READ,
        ST_WAIT,
        ST_TAIL,
        ST_SUSPENDING,
        ST_SUSP,
        ST_RESUMING
    } ecs_state_t;

    typedef struct packed {
        logic opInProgress;
        logic checksumAbortFlag;
        logic checksumSuspendedFlag;
    } ecs_status_t;

    typedef struct packed {
        logic              req;
        logic [ADDR_W-1:0] addr;
    } ecs_memreq_t;

    typedef struct packed {
        logic        detect;
        logic [23:0] addr;
    } ecs_eccev_t;

    typedef struct packed {
        logic       active;
        logic [3:0] ioOut;
        logic [3:0] ioOeN;
    } ecs_drv_t;
endpackage : ecs_pkg

// ==== verif/ecs_host_model.sv ====
// host link controller model for the checksum engine
`timescale 1ns/1ps

// ----------------------------------------
// frame driver, link clock still outside frames
// ----------------------------------------
module ecs_host_model (
    output logic            sck,
    output logic            csN,
    output logic [3:0]      ioIn,
    input  wire logic [3:0] ioOut,
    input  wire logic [1:0] laneMode
);
    int w;
    assign w = (laneMode == 2'h2) ? 4 : (laneMode == 2'h1) ? 2 : 1;
    initial begin
        sck  = 1'b0;
        csN  = 1'b1;
        ioIn = 4'h0;
    end
    // n bits out msb first, then rdn bits in; frame closed right after
    task automatic xfer(input logic [63:0] tx, input int n, input int rdn,
                        output logic [7:0] rx);
        rx = 8'h00;
        csN <= 1'b0;
        for (int i = 0; i < n + rdn; i += w) begin
            ioIn <= (i < n) ? tx[63-i -: 4] >> (4 - w) : ~ioIn;
            #25;
            if (i >= n)
                rx = (w == 1) ? {rx[6:0], ioOut[1]} :
                     (w == 2) ? {rx[5:0], ioOut[1:0]} : {rx[3:0], ioOut};
            sck <= 1'b1;
            #62.5;
            sck <= 1'b0;
            #37.5;
        end
        csN  <= 1'b1;
        ioIn <= ~ioIn;
        #300;
    endtask : xfer
endmodule : ecs_host_model

// ==== verif/ecs_engine_checker.sv ====
// port assertions of the checksum engine
`timescale 1ns/1ps

// ----------------------------------------
// checker
// ----------------------------------------
module ecs_engine_checker
    import ecs_pkg::*;
(
    input wire logic                 clk,
    input wire logic                 sys_rst,
    input wire logic                 csN,
    input wire logic [3:0]           ioOeN,
    input wire logic                 writeEnableLatchClr,
    input wire ecs_pkg::ecs_eccev_t  eccEvent,
    input wire ecs_pkg::ecs_status_t status,
    input wire logic [31:0]          checksumResultReg,
    input wire logic [31:0]          firstErrorAddressTrap,
    input wire logic [15:0]          doubleErrorCounter
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    property p_abort;
        $rose(status.checksumAbortFlag) |-> !status.opInProgress;
    endproperty
    a_abort: assert property (p_abort) else $error("abort while busy");
    property p_susp;
        $rose(status.checksumSuspendedFlag) |-> $past(status.opInProgress) && !status.opInProgress;
    endproperty
    a_susp: assert property (p_susp) else $error("suspend without run");
    property p_resume;
        $fell(status.checksumSuspendedFlag) |-> status.opInProgress;
    endproperty
    a_resume: assert property (p_resume) else $error("resume not busy");
    property p_zero;
        $rose(status.opInProgress) && !$past(status.checksumSuspendedFlag)
            |-> checksumResultReg == RESULT_RST;
    endproperty
    a_zero: assert property (p_zero) else $error("result not cleared");
    property p_start;
        $rose(status.opInProgress) |-> $past(csN, 2) && csN;
    endproperty
    a_start: assert property (p_start) else $error("start before frame end");
    property p_count;
        eccEvent.detect && doubleErrorCounter != CNT_MAX
            |=> doubleErrorCounter == $past(doubleErrorCounter) + 16'h0001;
    endproperty
    a_count: assert property (p_count) else $error("counter step");
    property p_trap;
        eccEvent.detect && doubleErrorCounter == CNT_RST
            |=> firstErrorAddressTrap == {8'h00, $past(eccEvent.addr[23:3]), 3'h0};
    endproperty
    a_trap: assert property (p_trap) else $error("trap capture");
    property p_hold;
        eccEvent.detect && doubleErrorCounter != CNT_RST |=> $stable(firstErrorAddressTrap);
    endproperty
    a_hold: assert property (p_hold) else $error("trap overwritten");
    property p_release;
        csN |-> ioOeN == 4'hf;
    endproperty
    a_release: assert property (p_release) else $error("lanes driven");
    c_abort: cover property ($rose(status.checksumAbortFlag));
    c_susp: cover property ($rose(status.checksumSuspendedFlag));
    c_welclr: cover property (writeEnableLatchClr);
endmodule : ecs_engine_checker

bind ecs_engine ecs_engine_checker u_checker (
    .clk(clk), .sys_rst(sys_rst), .csN(csN), .ioOeN(ioOeN),
    .writeEnableLatchClr(writeEnableLatchClr), .eccEvent(eccEvent), .status(status),
    .checksumResultReg(checksumResultReg), .firstErrorAddressTrap(firstErrorAddressTrap),
    .doubleErrorCounter(doubleErrorCounter)
);

// ==== verif/ecs_engine_bench.sv ====
// self-checking bench of the checksum engine
`timescale 1ns/1ps

// ----------------------------------------
// bench top
// ----------------------------------------
module ecs_engine_bench;
    import ecs_pkg::*;
    logic        clk, sys_rst, sck, csN, write_enable_latch, welClr, memValid, sawBusy, sawClr;
    logic [3:0]  ioIn, ioOut, ioOeN, latCode;
    logic [1:0]  laneMode;
    logic [7:0]  memData, rx;
    logic [15:0] errCnt;
    logic [31:0] result, trap;
    logic [23:0] rb [3] = '{24'h10, 24'h40, 24'h101};
    logic [23:0] re [3] = '{24'h16, 24'h43, 24'h10a};
    ecs_memreq_t memReq;
    ecs_eccev_t  eccEvent;
    ecs_status_t status;
    int          mismatches, num_checks;

    ecs_engine dut (.clk(clk), .sys_rst(sys_rst), .sck(sck), .csN(csN), .ioIn(ioIn),
        .ioOut(ioOut), .ioOeN(ioOeN), .laneMode(laneMode), .memoryLatencyCode(latCode),
        .writeEnableLatch(write_enable_latch), .writeEnableLatchClr(welClr), .memReq(memReq),
        .memValid(memValid), .memData(memData), .eccEvent(eccEvent), .status(status),
        .checksumResultReg(result), .firstErrorAddressTrap(trap), .doubleErrorCounter(errCnt));
    ecs_host_model host (.sck(sck), .csN(csN), .ioIn(ioIn), .ioOut(ioOut), .laneMode(laneMode));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    function automatic logic [7:0] memByte(input logic [17:0] a);
        return a[7:0] ^ a[15:8] ^ 8'ha5;
    endfunction : memByte

    function automatic logic [31:0] crcRef(input int b, input int e);
        logic [31:0] c, d;
        c = 32'h0;
        for (int a = b; a <= e; a += 4) begin
            d = 32'h0;
            for (int k = 0; k < 4 && a + k <= e; k++)
                d[31-8*k -: 8] = memByte(18'(a + k));
            c = c ^ d;
            repeat (32) c = c[31] ? (c << 1) ^ CRC_POLY : c << 1;
        end
        return c;
    endfunction : crcRef

    // array and latch stand-in
    always @(posedge clk) begin
        memValid <= memReq.req;
        memData  <= memByte(memReq.addr);
        if (welClr) begin
            write_enable_latch    <= 1'b0;
            sawClr <= 1'b1;
        end
        if (status.opInProgress)
            sawBusy <= 1'b1;
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude

    task automatic cmd(input logic [7:0] op);
        host.xfer({op, 56'h0}, 8, 0, rx);
    endtask : cmd

    task automatic setLane(input int m);
        laneMode <= 2'(m);
        latCode  <= 4'(4 + m);
        @(posedge clk);
        cmd(8'h00);
    endtask : setLane

    task automatic unitRead(input logic [23:0] a, input logic [7:0] exp);
        host.xfer({OPC_ECC_STATUS, a, 32'h0}, 32 + int'(latCode) * host.w, 8, rx);
        chk("unit status", {24'h0, rx}, {24'h0, exp});
    endtask : unitRead

    task automatic eccInject(input logic [23:0] a);
        @(posedge clk);
        eccEvent <= '{detect: 1'b1, addr: a};
        @(posedge clk);
        eccEvent <= '{detect: 1'b0, addr: a};
        repeat (2) @(posedge clk);
        #1;
    endtask : eccInject

    task automatic waitIdle();
        for (int i = 0; i < 3000 && status.opInProgress !== 1'b0; i++)
            @(posedge clk);
        #1;
    endtask : waitIdle

    task automatic ckStart(input logic [23:0] b, input logic [23:0] e);
        sawBusy = 1'b0;
        host.xfer({OPC_CK_START, b, e, 8'h00}, 56, 0, rx);
        chk("busy", 32'(sawBusy), 32'h1);
    endtask : ckStart

    task automatic ckEnd(input logic [23:0] b, input logic [23:0] e);
        waitIdle();
        chk("status", 32'(status), 32'h0);
        chk("result", result, crcRef(b, e));
    endtask : ckEnd

    initial begin
        #1_000_000;
        mismatches++;
        conclude();
    end

    initial begin
        sys_rst  = 1'b1;
        laneMode = 2'h0;
        latCode  = 4'h4;
        write_enable_latch      = 1'b0;
        memValid = 1'b0;
        memData  = 8'h00;
        eccEvent = '0;
        sawBusy  = 1'b0;
        sawClr   = 1'b0;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk("status", 32'(status), 32'h0);
        chk("result", result, 32'h0);
        chk("count", 32'(errCnt), 32'h0);
        $display("test reset done");
        eccInject(24'h000123);
        eccInject(24'h0004f8);
        chk("count", 32'(errCnt), 32'h2);
        chk("trap", trap, 32'h00000120);
        for (int m = 0; m < 3; m++) begin
            setLane(m);
            unitRead(24'h000127, 8'h08);
            unitRead(24'h000200, 8'h00);
        end
        cmd(OPC_ECC_CLEAR);
        chk("count", 32'(errCnt), 32'h0);
        chk("trap", trap, 32'h0);
        unitRead(24'h000120, 8'h00);
        eccInject(24'h000abc);
        chk("trap", trap, 32'h00000ab8);
        $display("test ecc done");
        write_enable_latch <= 1'b1;
        for (int m = 0; m < 3; m++) begin
            setLane(m);
            ckStart(rb[m], re[m]);
            ckEnd(rb[m], re[m]);
        end
        chk("latch clear", 32'(sawClr), 32'h1);
        cmd(OPC_CK_SUSPEND);
        cmd(OPC_CK_RESUME);
        chk("status", 32'(status), 32'h0);
        host.xfer({OPC_CK_START, 24'h20, 24'h22, 8'h00}, 56, 0, rx);
        chk("abort", 32'(status), 32'h2);
        $display("test checksum done");
        ckStart(24'h0, 24'h7f);
        cmd(OPC_CK_SUSPEND);
        waitIdle();
        chk("status", 32'(status), 32'h1);
        unitRead(24'h000ab8, 8'h08);
        host.xfer({OPC_CK_START, 24'h200, 24'h210, 8'h00}, 56, 0, rx);
        chk("status", 32'(status), 32'h1);
        cmd(OPC_CK_RESUME);
        chk("status", 32'(status), 32'h4);
        ckEnd(24'h0, 24'h7f);
        $display("test suspend done");
        conclude();
    end
endmodule : ecs_engine_bench
